// [rtl/cwpc_top.sv]
// Comms watchdog, protocol select and turnaround pause with an AHB-Lite slave.
//
// Overview of operation
// RQ1: Codes 11,12,13,15 decode to Ethernet protocols.
// RQ2: Link state 0..3 reported, read-only.
// RQ3: Flag rises when silence exceeds timeout.
// RQ4: Timeout zero disables the watchdog.
// RQ5: Policy 0 manual clear, 1 automatic.
// RQ6: Recovery window applies in automatic mode only.
// RQ7: Zero recovery clears on first message.
// RQ8: Nonzero recovery needs two messages in window.
// RQ9: Flag indicator reads 0 inactive, 1 active.
// RQ10: Pause option inserts delay before reply.
// RQ11: Pause only for serial RTU and bisync.
// RQ12: Time resolution code ms, s, min, h.
// RQ13: Watchdog supervises serial RTU and TCP.
// RQ14: Each valid message restarts silence timer.
// RQ15: Codes 1, 3, 10 decode likewise.
`timescale 1ns/100ps
module cwpc_top import cwpc_pkg::*; #(
   parameter int MS_CYC = MS_NS / CLK_NS // Clock cycles per millisecond tick.
) (
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_rst,
   // AHB-Lite slave.
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // Protocol engine events and state.
   input wire logic i_msg_valid,
   input wire logic i_rx_end,
   input wire logic [1:0] i_link_state,
   // Block outputs.
   output logic o_wd_flag,
   output logic o_tx_go,
   output cwpc_proto_s o_proto,
   output logic [1:0] o_time_resolution,
   output logic o_irq
);
   localparam logic [CNT_W-1:0] MS_LAST = CNT_W'(MS_CYC - 1); // Prescaler top.
   localparam logic [CNT_W-1:0] PAUSE_LAST = CNT_W'(PAUSE_CYC - 1); // Pause top.

   cwpc_st_s st; // Registered state.
   cwpc_st_s next_st; // Next state.
   logic [CNT_W-1:0] presc_cnt; // Millisecond prescaler.
   logic [CNT_W-1:0] sil_cnt; // Milliseconds since the last message.
   logic [CNT_W-1:0] rcv_cnt; // Milliseconds since the recovery window opened.
   logic [CNT_W-1:0] pause_cnt; // Cycles since the received frame ended.
   logic ms_tick; // One cycle each millisecond.
   logic wd_proto; // Protocol is one the watchdog supervises.
   logic wd_en; // Watchdog enabled.
   logic wd_raise; // Silence exceeded the timeout this cycle.
   logic rcv_restart; // Message opens a fresh recovery window.
   logic pause_proto; // Protocol takes the turnaround pause.
   logic pause_on; // Pause is to be inserted.
   logic bus_go; // Address phase taken.
   logic [31:0] rd_val; // Read value for the address in the address phase.
   cwpc_proto_s dec; // Decoded protocol selector.

   // Timers share one counter module.
   cwpc_cnt u_presc (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_clr(ms_tick),
      .i_inc(1'b1),
      .o_cnt(presc_cnt)
   );
   cwpc_cnt u_silence (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_clr(i_msg_valid || !wd_en), // RQ14
      .i_inc(ms_tick),
      .o_cnt(sil_cnt)
   );
   cwpc_cnt u_recover (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_clr(rcv_restart), // RQ6
      .i_inc(ms_tick),
      .o_cnt(rcv_cnt)
   );
   cwpc_cnt u_pause (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_clr(i_rx_end),
      .i_inc(1'b1),
      .o_cnt(pause_cnt)
   );

   // Protocol decode and the timing conditions derived from it.
   always_comb begin
      dec = '0;
      case (st.protocol_select)
         PSEL_RTU_SLAVE: dec.rtu_slave = 1'b1; // RQ15
         PSEL_RTU_MASTER: dec.rtu_master = 1'b1; // RQ15
         PSEL_BISYNC: dec.bisync = 1'b1;
         PSEL_NONE_SERIAL: dec.no_protocol = 1'b1;
         PSEL_NONE_ETH: dec.no_protocol = 1'b1; // RQ15
         PSEL_TCP_SLAVE_ONLY: dec.tcp_slave_only = 1'b1; // RQ1
         PSEL_IETH_PLUS_TCP: dec.industrial_eth_plus_tcp = 1'b1; // RQ1
         PSEL_BLDG_AUTO: dec.building_auto = 1'b1; // RQ1
         PSEL_MASTER_AND_SLAVE: dec.master_and_slave = 1'b1; // RQ1
         default: dec = '0;
      endcase
      ms_tick = (presc_cnt == MS_LAST);
      // Serial RTU and every TCP flavour are supervised.
      wd_proto = dec.rtu_slave || dec.rtu_master || dec.tcp_slave_only
         || dec.industrial_eth_plus_tcp || dec.master_and_slave; // RQ13
      wd_en = wd_proto && (st.tmo != TMO_RST); // RQ4
      wd_raise = wd_en && !st.flag && (sil_cnt > st.tmo); // RQ3
      rcv_restart = i_msg_valid && st.flag && st.flag_clear_policy
         && (!st.armed || rcv_cnt > st.recovery_window); // RQ8
      pause_proto = dec.rtu_slave || dec.rtu_master || dec.bisync; // RQ11
      pause_on = st.turnaround_pause && pause_proto; // RQ10
      bus_go = i_hsel && i_htrans[1] && i_hready;
   end

   // Read multiplexer; unmapped addresses read as zero.
   always_comb begin
      rd_val = 32'h0000_0000;
      case (i_haddr[7:0])
         CTRL_OFS: begin
            rd_val[CTRL_PSEL_LSB +: 4] = st.protocol_select;
            rd_val[CTRL_POLICY_BIT] = st.flag_clear_policy;
            rd_val[CTRL_PAUSE_BIT] = st.turnaround_pause;
            rd_val[CTRL_TRES_LSB +: 2] = st.time_resolution;
         end
         TMO_OFS: rd_val[CNT_W-1:0] = st.tmo;
         RCV_OFS: rd_val[CNT_W-1:0] = st.recovery_window;
         STAT_OFS: begin
            rd_val[STAT_FLAG_BIT] = st.flag; // RQ9
            rd_val[STAT_LINK_LSB +: 2] = st.link_state; // RQ2
            rd_val[STAT_WDEN_BIT] = wd_en;
         end
         ISTAT_OFS: rd_val[1:0] = st.istat;
         IMASK_OFS: rd_val[1:0] = st.imask;
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // Next-state logic: bus, watchdog, pause and interrupts.
   always_comb begin
      next_st = st;
      next_st.rdy = 1'b1;
      next_st.resp = 1'b0;
      next_st.tx_go = 1'b0;
      next_st.link_state = i_link_state; // RQ2
      next_st.proto = dec;
      next_st.wr_pend = bus_go && i_hwrite;
      next_st.hrdata = 32'h0000_0000;
      if (bus_go) begin
         next_st.wr_addr = i_haddr[7:0];
      end
      // Read in the address phase; an interrupt status read clears the sticky bits.
      if (bus_go && !i_hwrite) begin
         next_st.hrdata = rd_val;
         if (i_haddr[7:0] == ISTAT_OFS) begin
            next_st.istat = 2'h0;
         end
      end
      // Write data phase; the link state is not writable.
      if (st.wr_pend) begin
         case (st.wr_addr)
            CTRL_OFS: begin
               next_st.protocol_select = i_hwdata[CTRL_PSEL_LSB +: 4];
               next_st.flag_clear_policy = i_hwdata[CTRL_POLICY_BIT]; // RQ5
               next_st.turnaround_pause = i_hwdata[CTRL_PAUSE_BIT];
               next_st.time_resolution = i_hwdata[CTRL_TRES_LSB +: 2]; // RQ12
            end
            TMO_OFS: next_st.tmo = i_hwdata[CNT_W-1:0];
            RCV_OFS: next_st.recovery_window = i_hwdata[CNT_W-1:0];
            STAT_OFS: begin
               // Manual clear of the flag by writing one.
               if (i_hwdata[STAT_FLAG_BIT] && !st.flag_clear_policy) begin
                  next_st.flag = 1'b0; // RQ5
               end
            end
            IMASK_OFS: next_st.imask = i_hwdata[1:0];
            default: next_st.imask = next_st.imask;
         endcase
      end
      // Watchdog flag; raising wins over a clear in the same cycle.
      if (wd_raise) begin
         next_st.flag = 1'b1; // RQ3
         next_st.armed = 1'b0;
      end else if (st.flag && st.flag_clear_policy && i_msg_valid) begin
         if (st.recovery_window == RCV_RST) begin
            next_st.flag = 1'b0; // RQ7
         end else if (st.armed && rcv_cnt <= st.recovery_window) begin
            next_st.flag = 1'b0; // RQ8
            next_st.armed = 1'b0;
         end else begin
            next_st.armed = 1'b1; // RQ6
         end
      end
      if (!next_st.flag) begin
         next_st.armed = 1'b0;
      end
      // Turnaround pause between frame end and reply.
      if (i_rx_end) begin
         if (pause_on) begin
            next_st.pausing = 1'b1; // RQ10
         end else begin
            next_st.tx_go = 1'b1; // RQ10
         end
      end else if (st.pausing && pause_cnt == PAUSE_LAST) begin
         next_st.pausing = 1'b0;
         next_st.tx_go = 1'b1;
      end
      // Sticky events are set after the read clear, so they are not lost.
      if (next_st.flag && !st.flag) begin
         next_st.istat[IRQ_RAISE_BIT] = 1'b1;
      end
      if (!next_st.flag && st.flag) begin
         next_st.istat[IRQ_CLEAR_BIT] = 1'b1;
      end
      next_st.irq = |(next_st.istat & next_st.imask);
   end

   // State register with constant reset values.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         st <= '0;
         st.protocol_select <= PSEL_RST;
         st.flag_clear_policy <= POLICY_RST;
         st.turnaround_pause <= PAUSE_RST;
         st.time_resolution <= TRES_RST;
         st.tmo <= TMO_RST;
         st.recovery_window <= RCV_RST;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register.
   assign o_hrdata = st.hrdata;
   assign o_hreadyout = st.rdy;
   assign o_hresp = st.resp;
   assign o_wd_flag = st.flag; // RQ9
   assign o_tx_go = st.tx_go;
   assign o_proto = st.proto;
   assign o_time_resolution = st.time_resolution; // RQ12
   assign o_irq = st.irq;

   // Checks of the watchdog, pause and decode behaviour.
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);

   flag_rise_a: assert property (wd_raise |=> o_wd_flag) // RQ3
      else $error("flag did not rise after timeout");
   wd_off_a: assert property (!wd_en |=> !$rose(o_wd_flag)) // RQ4
      else $error("flag rose with watchdog disabled");
   manual_hold_a: assert property ((st.flag && !st.flag_clear_policy // RQ5
      && !(st.wr_pend && st.wr_addr == STAT_OFS)) |=> o_wd_flag)
      else $error("manual flag cleared without a write");
   quick_clear_a: assert property ((st.flag && st.flag_clear_policy // RQ7
      && st.recovery_window == RCV_RST && i_msg_valid) |=> !o_wd_flag)
      else $error("flag not cleared by first message");
   two_msg_a: assert property ((st.flag && st.flag_clear_policy // RQ8
      && st.recovery_window != RCV_RST && !st.armed && i_msg_valid) |=> o_wd_flag)
      else $error("flag cleared by a single message");
   flag_cause_a: assert property ($rose(o_wd_flag) |-> $past(wd_raise)) // RQ9
      else $error("flag rose without timeout");
   no_pause_a: assert property ((i_rx_end && !pause_on) |=> o_tx_go) // RQ10
      else $error("reply start delayed without pause");
   pause_gap_a: assert property ((i_rx_end && pause_on) |=> !o_tx_go [*8]) // RQ11
      else $error("reply started during pause");
   sil_restart_a: assert property (i_msg_valid |=> sil_cnt == '0) // RQ14
      else $error("silence timer not restarted");
   proto_dec_a: assert property ((st.protocol_select == PSEL_TCP_SLAVE_ONLY) // RQ1
      |=> o_proto.tcp_slave_only)
      else $error("tcp slave code not decoded");
   rtu_dec_a: assert property ((st.protocol_select == PSEL_RTU_MASTER) // RQ15
      |=> o_proto.rtu_master)
      else $error("rtu master code not decoded");
   // The reply starts one cycle after the pause counter reaches its top.
   pause_end_a: assert property ((st.pausing && !i_rx_end && pause_cnt == PAUSE_LAST) // RQ10
      |=> (o_tx_go && !st.pausing))
      else $error("reply not started at pause end");
   // A rising flag always leaves its sticky raise event behind.
   raise_event_a: assert property ($rose(o_wd_flag) |-> st.istat[IRQ_RAISE_BIT]) // RQ3
      else $error("raise event not recorded");
   // The interrupt follows the unmasked sticky bits.
   irq_level_a: assert property (o_irq == |(st.istat & st.imask))
      else $error("interrupt level wrong");
   // Every transfer is answered at once, and always with OKAY.
   bus_okay_a: assert property (bus_go |=> (o_hreadyout && !o_hresp))
      else $error("bus answer not ready or not okay");

   timeout_seen_c: cover property (wd_raise ##[1:20] (o_wd_flag && i_msg_valid));
   auto_clear_c: cover property ($fell(o_wd_flag) && st.flag_clear_policy);
   pause_done_c: cover property (st.pausing ##1 o_tx_go);
   manual_clear_c: cover property (st.flag && !st.flag_clear_policy ##1 !st.flag);
   window_open_c: cover property (rcv_restart);
endmodule

// [rtl/cwpc_pkg.sv]
// Package of constants, codes and carrier types for the comms watchdog block.
package cwpc_pkg;
   // Register byte offsets on the AHB-Lite slave.
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] TMO_OFS = 8'h04;
   localparam logic [7:0] RCV_OFS = 8'h08;
   localparam logic [7:0] STAT_OFS = 8'h0C;
   localparam logic [7:0] ISTAT_OFS = 8'h10;
   localparam logic [7:0] IMASK_OFS = 8'h14;
   // Field positions of the control and status words.
   localparam int CTRL_PSEL_LSB = 0;
   localparam int CTRL_POLICY_BIT = 8;
   localparam int CTRL_PAUSE_BIT = 9;
   localparam int CTRL_TRES_LSB = 12;
   localparam int STAT_FLAG_BIT = 0;
   localparam int STAT_LINK_LSB = 4;
   localparam int STAT_WDEN_BIT = 8;
   localparam int IRQ_RAISE_BIT = 0;
   localparam int IRQ_CLEAR_BIT = 1;
   // Width of the timing counters and the time registers.
   localparam int CNT_W = 16;
   // Protocol selector codes.
   localparam logic [3:0] PSEL_NONE_SERIAL = 4'h0;
   localparam logic [3:0] PSEL_RTU_SLAVE = 4'h1;
   localparam logic [3:0] PSEL_BISYNC = 4'h2;
   localparam logic [3:0] PSEL_RTU_MASTER = 4'h3;
   localparam logic [3:0] PSEL_NONE_ETH = 4'hA;
   localparam logic [3:0] PSEL_TCP_SLAVE_ONLY = 4'hB;
   localparam logic [3:0] PSEL_IETH_PLUS_TCP = 4'hC;
   localparam logic [3:0] PSEL_BLDG_AUTO = 4'hD;
   localparam logic [3:0] PSEL_MASTER_AND_SLAVE = 4'hF;
   // Link state codes.
   localparam logic [1:0] STATE_OFFLINE = 2'h0;
   localparam logic [1:0] STATE_INITIALIZING = 2'h1;
   localparam logic [1:0] STATE_READY_TO_ACCEPT = 2'h2;
   localparam logic [1:0] STATE_READY = 2'h3;
   // Time resolution codes for scaled integer access.
   localparam logic [1:0] TRES_MS = 2'h0;
   localparam logic [1:0] TRES_SEC = 2'h1;
   localparam logic [1:0] TRES_MIN = 2'h2;
   localparam logic [1:0] TRES_HOUR = 2'h3;
   // Reset values.
   localparam logic [3:0] PSEL_RST = PSEL_TCP_SLAVE_ONLY;
   localparam logic POLICY_RST = 1'b0;
   localparam logic PAUSE_RST = 1'b0;
   localparam logic [1:0] TRES_RST = TRES_MS;
   localparam logic [CNT_W-1:0] TMO_RST = 16'h0000;
   localparam logic [CNT_W-1:0] RCV_RST = 16'h0000;
   // Timing: clock period, millisecond tick and turnaround pause.
   localparam int CLK_NS = 25;
   localparam int MS_NS = 1000000;
   localparam int PAUSE_NS = 100000;
   localparam int PAUSE_CYC = (PAUSE_NS + CLK_NS - 1) / CLK_NS;
   // Decoded protocol flags.
   typedef struct packed {
      logic rtu_slave;
      logic rtu_master;
      logic bisync;
      logic no_protocol;
      logic tcp_slave_only;
      logic industrial_eth_plus_tcp;
      logic building_auto;
      logic master_and_slave;
   } cwpc_proto_s;
   // State of one saturating counter.
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } cwpc_cnt_s;
   // Whole state of the top module.
   typedef struct packed {
      logic [3:0] protocol_select;
      logic flag_clear_policy;
      logic turnaround_pause;
      logic [1:0] time_resolution;
      logic [CNT_W-1:0] tmo;
      logic [CNT_W-1:0] recovery_window;
      logic flag;
      logic armed;
      logic pausing;
      logic tx_go;
      logic [1:0] istat;
      logic [1:0] imask;
      logic irq;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] hrdata;
      logic rdy;
      logic resp;
      logic [1:0] link_state;
      cwpc_proto_s proto;
   } cwpc_st_s;
endpackage

// [rtl/cwpc_cnt.sv]
// Saturating up-counter with synchronous clear, used for all block timers.
`timescale 1ns/100ps
module cwpc_cnt import cwpc_pkg::*; (
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_rst,
   // Control.
   input wire logic i_clr,
   input wire logic i_inc,
   // Count value.
   output logic [CNT_W-1:0] o_cnt
);
   cwpc_cnt_s st; // Registered count.
   cwpc_cnt_s next_st; // Next count.

   // Clear wins over increment; the count sticks at its top value.
   always_comb begin
      next_st = st;
      if (i_clr) begin
         next_st.cnt = '0;
      end else if (i_inc && st.cnt != '1) begin
         next_st.cnt = st.cnt + 1'b1;
      end
   end

   // State register.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_cnt = st.cnt;
endmodule

// [testbench/cwpc_host_model.sv]
// Host-side model that drives message events, frame ends and the link state.
`timescale 1ns/100ps
module cwpc_host_model import cwpc_pkg::*; (
   // Clock.
   input wire logic i_mclk,
   // Engine events toward the block.
   output logic o_msg_valid,
   output logic o_rx_end,
   output logic [1:0] o_link_state
);
   // Everything idles low and offline at time zero.
   initial begin
      o_msg_valid = 1'b0;
      o_rx_end = 1'b0;
      o_link_state = STATE_OFFLINE;
   end
   // Sends n frames; msg says whether each one addresses us, gap sets the idle spacing.
   task automatic send(input int n, input int gap, input logic msg);
      repeat (n) begin
         @(posedge i_mclk);
         o_msg_valid <= msg;
         o_rx_end <= 1'b1;
         @(posedge i_mclk);
         o_msg_valid <= 1'b0;
         o_rx_end <= 1'b0;
         repeat (gap) @(posedge i_mclk);
      end
   endtask
   // Moves the link to a new state just after an edge.
   task automatic set_link(input logic [1:0] s);
      @(posedge i_mclk);
      o_link_state <= s;
   endtask
endmodule

// [testbench/cwpc_top_tb.sv]
// Self-checking bench for the comms watchdog block.
`timescale 1ns/100ps
module cwpc_top_tb import cwpc_pkg::*;;
   localparam int MS = 10; // Short millisecond tick keeps the run brief.
   logic clk, rst, hsel, hwrite, msg, rxe, flag, txgo, irq, hresp, e;
   logic [31:0] haddr, hwdata, hrdata, rd, v;
   logic [1:0] htrans, link, tres, m_istat;
   logic [2:0] hsize;
   wire logic hready;
   cwpc_proto_s proto;
   int n_mismatch = 0;
   int checks_done = 0;
   int n, t, r;
   logic [3:0] pc[9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF};
   logic [3:0] wc[8] = '{4'h1, 4'h3, 4'hB, 4'hC, 4'hF, 4'h2, 4'hD, 4'hB};
   logic [3:0] qc[5] = '{4'h1, 4'h2, 4'h3, 4'hB, 4'h1};
   logic qz[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
   // Free-running 40 MHz clock.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Design under test with a short tick.
   cwpc_top #(.MS_CYC(MS)) uut (.i_mclk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
      .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
      .i_msg_valid(msg), .i_rx_end(rxe), .i_link_state(link), .o_wd_flag(flag),
      .o_tx_go(txgo), .o_proto(proto), .o_time_resolution(tres), .o_irq(irq));
   // Far-side host.
   cwpc_host_model host (.i_mclk(clk), .o_msg_valid(msg), .o_rx_end(rxe), .o_link_state(link));
   // Compares a register word.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Compares a single output pin.
   task automatic chk1(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // One AHB-Lite single transfer; waits for hready in both phases.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clk);
      while (hready !== 1'b1 && k < 50) begin
         @(posedge clk);
         k++;
      end
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hready !== 1'b1 && k < 50) begin
         @(posedge clk);
         k++;
      end
      rd = hrdata;
      chk1(hresp, 1'b0);
      if (k >= 50) begin
         n_mismatch++;
         end_of_test;
      end
   endtask
   // Register write.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   // Register read compared with the expected word.
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h00000000);
      chk(rd, exp);
   endtask
   // Waits a bounded number of cycles for the flag to reach a level.
   task automatic wait_flag(input logic lv, input int lim);
      n = 0;
      while (flag !== lv && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask
   // One-hot decode expected for each protocol code.
   function automatic logic [7:0] exp_proto(input logic [3:0] c);
      case (c)
         4'h1: return 8'h80;
         4'h3: return 8'h40;
         4'h2: return 8'h20;
         4'h0, 4'hA: return 8'h10;
         4'hB: return 8'h08;
         4'hC: return 8'h04;
         4'hD: return 8'h02;
         4'hF: return 8'h01;
         default: return 8'h00;
      endcase
   endfunction
   // Hang guard.
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      end_of_test;
   end
   // Main sequence.
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      m_istat = 2'h0;
      r = $urandom(32636);
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // Reset values, plus an unmapped address.
      rdc(CTRL_OFS, 32'h0000000B);
      rdc(TMO_OFS, 32'h00000000);
      rdc(RCV_OFS, 32'h00000000);
      rdc(STAT_OFS, 32'h00000000);
      rdc(ISTAT_OFS, 32'h00000000);
      rdc(IMASK_OFS, 32'h00000000);
      rdc(8'h20, 32'h00000000);
      // Every protocol code with a random resolution and pause bit.
      for (int i = 0; i < 9; i++) begin
         v = 32'(pc[i]) | (32'($urandom % 4) << 12) | (32'($urandom % 2) << 9);
         wr(CTRL_OFS, v);
         rdc(CTRL_OFS, v);
         repeat (2) @(posedge clk);
         chk(32'(proto), 32'(exp_proto(pc[i])));
         chk(32'(tres), 32'(v[13:12]));
      end
      // Link state follows the engine and cannot be written.
      for (int s = 0; s < 4; s++) begin
         host.set_link(2'(s));
         @(posedge clk);
         rdc(STAT_OFS, 32'(s) << 4);
      end
      wr(STAT_OFS, 32'h00000130);
      rdc(STAT_OFS, 32'h00000030);
      // Silence supervision per protocol; the last pass has a zero timeout.
      for (int i = 0; i < 8; i++) begin
         t = (i == 7) ? 0 : 1 + $urandom % 3;
         wr(CTRL_OFS, 32'(wc[i]));
         wr(TMO_OFS, 32'(t));
         wr(IMASK_OFS, i[0] ? 32'h00000003 : 32'h00000000);
         r = 2 + $urandom % 4;
         host.send(1 + $urandom % 3, r, 1'b1);
         chk1(flag, 1'b0);
         e = (wc[i] inside {4'h1, 4'h3, 4'hB, 4'hC, 4'hF}) && t != 0;
         wait_flag(1'b1, (t + 2) * MS + 6);
         chk1(flag, e);
         if (e) begin
            chk1(n + r > t * MS, 1'b1);
            chk1(n + r <= (t + 1) * MS + 2, 1'b1);
            m_istat[0] = 1'b1;
            repeat (2) @(posedge clk);
            chk1(irq, i[0]);
            host.send(1, 0, 1'b1);
            chk1(flag, 1'b1);
            rdc(STAT_OFS, 32'h00000131);
            rdc(ISTAT_OFS, 32'(m_istat));
            m_istat = 2'h0;
            repeat (2) @(posedge clk);
            chk1(irq, 1'b0);
            wr(TMO_OFS, 32'h00000000);
            wr(STAT_OFS, 32'h00000001);
            repeat (2) @(posedge clk);
            chk1(flag, 1'b0);
            m_istat[1] = 1'b1;
         end
      end
      // Automatic clearing, first without and then with a recovery window.
      r = 1 + $urandom % 3;
      wr(CTRL_OFS, 32'h00000101);
      wr(TMO_OFS, 32'h00000001);
      host.send(1, 0, 1'b1);
      wait_flag(1'b1, 3 * MS + 6);
      chk1(flag, 1'b1);
      host.send(1, 0, 1'b1);
      wait_flag(1'b0, 3);
      chk1(flag, 1'b0);
      wr(RCV_OFS, 32'(r));
      wait_flag(1'b1, 3 * MS + 6);
      chk1(flag, 1'b1);
      host.send(1, 2, 1'b1);
      chk1(flag, 1'b1);
      host.send(1, 0, 1'b1);
      wait_flag(1'b0, 3);
      chk1(flag, 1'b0);
      wr(TMO_OFS, 32'h00000000);
      // Reply pause per protocol and option.
      for (int i = 0; i < 5; i++) begin
         wr(CTRL_OFS, 32'(qc[i]) | (32'(qz[i]) << 9));
         host.send(1, 0, 1'b0);
         n = 0;
         while (txgo !== 1'b1 && n < PAUSE_CYC + 20) begin
            @(posedge clk);
            n++;
         end
         e = qz[i] && (qc[i] inside {4'h1, 4'h2, 4'h3});
         chk(32'(n), e ? 32'(PAUSE_CYC + 1) : 32'h00000001);
         @(posedge clk);
         chk1(txgo, 1'b0);
      end
      end_of_test;
   end
endmodule
